// ---- hw/gemle_entry.sv ----
// Guest entry: register load walk followed by event injection
`timescale 1ns/1ns
`default_nettype none
`include "gemle_map.svh"
module gemle_entry (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic entryStart, // Pulse: begin a guest entry
    input wire logic entryInMgmtMode, // Entry began in management_interrupt_mode
    input wire logic [31:0] loadCount, // Number of load records
    input wire logic [127:0] recData, // Record read data
    input wire logic recValid, // Record read data valid
    input wire logic idxMgmtOnly, // Indexed register is management-mode only
    input wire logic idxForbidden, // Model forbids loading on entry
    input wire logic writeWouldFault, // Ordinary write would fault at privilege 0
    input wire logic [31:0] intrInfo, // Entry interruption field
    input wire logic [31:0] entryErrCode, // Entry error-code field
    input wire logic [31:0] entryInstrLen, // Entry instruction length
    input wire logic [63:0] guestFlags, // Loaded guest_flags_word
    input wire logic [63:0] guestIp, // Loaded guest_instruction_pointer
    input wire logic v86Mode, // Guest will be in 8086 mode
    input wire logic v86Ext, // v86_mode_extensions enabled
    input wire logic redirBit, // Redirection bitmap bit for the vector
    input wire logic [1:0] descPriv, // descriptor_privilege of target
    input wire logic [1:0] curPriv, // current_privilege
    input wire logic deliveryFault, // Delivery met a nested exception
    input wire logic [7:0] nestVector, // Vector of that nested exception
    input wire logic [31:0] excBitmap, // Exception bitmap
    input wire logic virtNmiCtl, // Virtual-NMI execution control
    output logic watchCancel, // Pulse: cancel address-range watch
    output logic recRead, // Request next record
    output logic [31:0] recIndex, // Record number requested
    output logic msrWrite, // Pulse: write register
    output logic [31:0] msrIdx, // Register index written
    output logic [63:0] msrData, // Value written
    output logic entryFail, // Pulse: entry failed, restore host state
    output logic entryDone, // Pulse: entry complete
    output logic deliverVec, // Pulse: deliver through descriptor table, or vector table when useVecTable
    output logic useVecTable, // Delivery uses table at linear address zero
    output logic [7:0] deliverVector, // Vector being delivered
    output logic mtfPending, // Monitor-trap exit pending
    output logic guestExit, // Pulse: nested exception exits
    output logic [63:0] exitSavedIp, // Pointer saved on exit
    output logic pushValid, // Pulse: stack word valid
    output logic [63:0] pushWord, // Stack word
    output logic vnmiBlock, // Virtual-NMI blocking after entry
    output logic debugRegWrite // Debug register update, held low
);
    ////////////////////////////////////////////////////////////////////////
    // State
    gemle_pkg::gemle_state_t state, next_state;
    logic [31:0] recCnt, next_recCnt; // Records processed
    logic [1:0] pushCnt, next_pushCnt; // Stack words pushed
    logic nestCnt, next_nestCnt; // Nested exceptions seen
    logic nestedPath, next_nestedPath; // Delivery met a nested exception
    logic checkStrobe; // Record check pulse
    logic recordFail; // Verdict for the checked record
    logic bufWe; // Push buffer write
    logic [1:0] bufWa; // Push buffer address
    logic [63:0] bufWd; // Push buffer data
    logic [63:0] bufRd; // Push buffer read data
    logic [127:0] recHold, next_recHold; // Held record
    gemle_pkg::gemle_itype_t iType; // Interruption type
    logic [63:0] pushFlags; // Flags image to push
    logic [63:0] pushIp; // Pointer to push
    logic redirected; // Redirected 8086 interrupt case
    logic next_watchCancel, next_recRead, next_msrWrite, next_entryFail, next_entryDone;
    logic next_deliverVec, next_useVecTable, next_mtfPending, next_guestExit;
    logic next_pushValid, next_vnmiBlock;
    logic [31:0] next_msrIdx;
    logic [63:0] next_msrData, next_exitSavedIp, next_pushWord;
    logic [7:0] next_deliverVector;

    // True for software-originated types
    function automatic logic isSoft(input gemle_pkg::gemle_itype_t t);
        isSoft = (t == gemle_pkg::SW_INT) || (t == gemle_pkg::PRIV_SW_EXC)
            || (t == gemle_pkg::SW_EXC);
    endfunction : isSoft

    ////////////////////////////////////////////////////////////////////////
    // Record checker and push store
    gemle_rec_check u_check (
        .ref_clk(ref_clk),
        .rst(rst),
        .checkStrobe(checkStrobe),
        .record(recHold),
        .entryInMgmtMode(entryInMgmtMode),
        .idxMgmtOnly(idxMgmtOnly),
        .idxForbidden(idxForbidden),
        .writeWouldFault(writeWouldFault),
        .recordFail(recordFail)
    );
    gemle_push_buf u_buf (
        .ref_clk(ref_clk),
        .writeEn(bufWe),
        .writeAddr(bufWa),
        .writeData(bufWd),
        .readAddr(pushCnt),
        .readData(bufRd)
    );

    ////////////////////////////////////////////////////////////////////////
    // Injection values
    always_comb begin
        iType = gemle_pkg::gemle_itype_t'(intrInfo[`GEMLE_TYPE_LO +: 3]);
        // 8086 redirection through the vector table
        redirected = (iType == gemle_pkg::SW_INT) && v86Mode && v86Ext && !redirBit;
        pushFlags = guestFlags;
        if (redirected && (guestFlags[`GEMLE_IO_PRIVILEGE_LEVEL_LO +: 2] != 2'h3)) begin
            pushFlags[`GEMLE_IO_PRIVILEGE_LEVEL_LO +: 2] = 2'h3;
            pushFlags[`GEMLE_IF_BIT] = guestFlags[`GEMLE_VIF_BIT];
        end
        // Software types add the instruction length
        pushIp = isSoft(iType) ? guestIp + {32'h0000_0000, entryInstrLen} : guestIp;
        // Nested exception keeps the pointer unadjusted
        if (nestedPath) begin
            pushIp = guestIp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_state = state;
        next_recCnt = recCnt;
        next_pushCnt = pushCnt;
        next_nestCnt = nestCnt;
        next_nestedPath = nestedPath;
        next_recHold = recHold;
        next_watchCancel = 1'b0;
        next_recRead = 1'b0;
        next_msrWrite = 1'b0;
        next_msrIdx = msrIdx;
        next_msrData = msrData;
        next_entryFail = 1'b0;
        next_entryDone = 1'b0;
        next_deliverVec = 1'b0;
        next_useVecTable = useVecTable;
        next_deliverVector = deliverVector;
        next_mtfPending = mtfPending;
        next_guestExit = 1'b0;
        next_exitSavedIp = exitSavedIp;
        next_pushValid = 1'b0;
        next_pushWord = pushWord;
        next_vnmiBlock = vnmiBlock;
        checkStrobe = 1'b0;
        bufWe = 1'b0;
        bufWa = 2'h0;
        bufWd = 64'h0000_0000_0000_0000;
        case (state)
            gemle_pkg::IDLE: begin
                if (entryStart) begin
                    next_watchCancel = 1'b1;
                    next_recCnt = 32'h0000_0000;
                    next_mtfPending = 1'b0;
                    next_vnmiBlock = 1'b0;
                    next_nestedPath = 1'b0;
                    next_nestCnt = 1'b0;
                    next_state = gemle_pkg::FETCH;
                end
            end
            gemle_pkg::FETCH: begin
                // Walk records in order up to count
                if (recCnt == loadCount) begin
                    next_state = gemle_pkg::INJECT;
                end else begin
                    next_recRead = 1'b1;
                    next_state = gemle_pkg::WAITREC;
                end
            end
            gemle_pkg::WAITREC: begin
                if (recValid) begin
                    next_recHold = recData;
                    next_state = gemle_pkg::CHECK;
                end
            end
            gemle_pkg::CHECK: begin
                checkStrobe = 1'b1;
                next_state = gemle_pkg::WRITE;
            end
            gemle_pkg::WRITE: begin
                if (recordFail) begin
                    next_state = gemle_pkg::FAIL;
                end else begin
                    // Register write of the record value
                    next_msrWrite = 1'b1;
                    next_msrIdx = recHold[31:0];
                    next_msrData = recHold[127:64];
                    if (recHold[31:0] == `GEMLE_IDX_EXT_FEAT) begin
                        next_msrData[`GEMLE_LMA_BIT] = 1'b0;
                    end
                    next_recCnt = recCnt + 32'h0000_0001;
                    next_state = gemle_pkg::FETCH;
                end
            end
            gemle_pkg::INJECT: begin
                if (!intrInfo[`GEMLE_VALID_BIT]) begin
                    next_state = gemle_pkg::DONE;
                end else if (iType == gemle_pkg::OTHER) begin
                    next_mtfPending = (intrInfo[7:0] == 8'h00);
                    next_state = gemle_pkg::DONE;
                end else if (iType == gemle_pkg::RSVD1) begin
                    next_state = gemle_pkg::DONE;
                end else begin
                    next_deliverVec = 1'b1;
                    next_deliverVector = intrInfo[7:0];
                    next_useVecTable = redirected;
                    next_vnmiBlock = (iType == gemle_pkg::NMI) && virtNmiCtl;
                    next_state = gemle_pkg::DELIVER;
                end
            end
            gemle_pkg::DELIVER: begin
                if (deliveryFault || ((iType == gemle_pkg::SW_INT && !redirected
                        || iType == gemle_pkg::SW_EXC) && descPriv < curPriv)) begin
                    next_nestedPath = 1'b1;
                    next_state = gemle_pkg::NESTED;
                end else begin
                    next_state = gemle_pkg::PUSH;
                end
                next_pushCnt = 2'h0;
                bufWe = 1'b1;
                bufWd = pushFlags;
            end
            gemle_pkg::NESTED: begin
                if (excBitmap[nestVector[4:0]]) begin
                    next_guestExit = 1'b1;
                    next_exitSavedIp = guestIp;
                    next_state = gemle_pkg::DONE;
                end else begin
                    next_state = gemle_pkg::PUSH;
                end
            end
            gemle_pkg::PUSH: begin
                // Pointer, error code, then drain
                bufWe = 1'b1;
                bufWa = pushCnt + 2'h1;
                if (pushCnt == 2'h0) begin
                    bufWd = pushIp;
                end else if (nestedPath) begin
                    // External flag; double fault code zero
                    bufWd = {32'h0000_0000, nestCnt ? `GEMLE_DF_CODE
                        : {31'h0000_0000, !isSoft(iType) || iType == gemle_pkg::PRIV_SW_EXC}};
                end else begin
                    bufWd = {32'h0000_0000, entryErrCode};
                end
                next_pushValid = (pushCnt != 2'h0);
                next_pushWord = bufRd;
                next_pushCnt = pushCnt + 2'h1;
                if (pushCnt == 2'h3 || (pushCnt == 2'h2 && !nestedPath
                        && !intrInfo[`GEMLE_DELIV_ERR_BIT])) begin
                    next_state = gemle_pkg::DONE;
                end
            end
            gemle_pkg::DONE: begin
                next_entryDone = 1'b1;
                next_state = gemle_pkg::IDLE;
            end
            gemle_pkg::FAIL: begin
                next_entryFail = 1'b1;
                next_state = gemle_pkg::IDLE;
            end
            default: begin
                next_state = gemle_pkg::IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= gemle_pkg::IDLE;
            recCnt <= 32'h0000_0000;
            pushCnt <= 2'h0;
            nestCnt <= 1'b0;
            nestedPath <= 1'b0;
            recHold <= 128'h0;
            watchCancel <= 1'b0;
            recRead <= 1'b0;
            recIndex <= 32'h0000_0000;
            msrWrite <= 1'b0;
            msrIdx <= 32'h0000_0000;
            msrData <= 64'h0000_0000_0000_0000;
            entryFail <= 1'b0;
            entryDone <= 1'b0;
            deliverVec <= 1'b0;
            useVecTable <= 1'b0;
            deliverVector <= 8'h00;
            mtfPending <= 1'b0;
            guestExit <= 1'b0;
            exitSavedIp <= 64'h0000_0000_0000_0000;
            pushValid <= 1'b0;
            pushWord <= 64'h0000_0000_0000_0000;
            vnmiBlock <= 1'b0;
        end else begin
            state <= next_state;
            recCnt <= next_recCnt;
            pushCnt <= next_pushCnt;
            nestCnt <= next_nestCnt;
            nestedPath <= next_nestedPath;
            recHold <= next_recHold;
            watchCancel <= next_watchCancel;
            recRead <= next_recRead;
            recIndex <= recCnt;
            msrWrite <= next_msrWrite;
            msrIdx <= next_msrIdx;
            msrData <= next_msrData;
            entryFail <= next_entryFail;
            entryDone <= next_entryDone;
            deliverVec <= next_deliverVec;
            useVecTable <= next_useVecTable;
            deliverVector <= next_deliverVector;
            mtfPending <= next_mtfPending;
            guestExit <= next_guestExit;
            exitSavedIp <= next_exitSavedIp;
            pushValid <= next_pushValid;
            pushWord <= next_pushWord;
            vnmiBlock <= next_vnmiBlock;
        end
    end
    // Debug state is never written by injection
    always_ff @(posedge ref_clk) begin
        debugRegWrite <= 1'b0;
    end
endmodule : gemle_entry
`default_nettype wire

// ---- hw/gemle_map.svh ----
// Constants for the guest entry register load and event injection block
`ifndef GEMLE_MAP_SVH
`define GEMLE_MAP_SVH
`define GEMLE_IDX_FS_BASE 32'hC000_0100
`define GEMLE_IDX_GS_BASE 32'hC000_0101
`define GEMLE_IDX_CTRL_HI 24'h00_0008
`define GEMLE_IDX_EXT_FEAT 32'hC000_0080
`define GEMLE_LMA_BIT 10
`define GEMLE_IF_BIT 9
`define GEMLE_IO_PRIVILEGE_LEVEL_LO 12
`define GEMLE_VIF_BIT 19
`define GEMLE_RF_BIT 16
`define GEMLE_DELIV_ERR_BIT 11
`define GEMLE_TYPE_LO 8
`define GEMLE_VALID_BIT 31
`define GEMLE_VEC_GP 8'h0D
`define GEMLE_VEC_DF 8'h08
`define GEMLE_DF_CODE 32'h0000_0000
`endif

// ---- hw/gemle_pkg.sv ----
// Types for the guest entry register load and event injection block
package gemle_pkg;
    // Main sequencer states
    typedef enum logic [3:0] {
        IDLE, FETCH, WAITREC, CHECK, WRITE, INJECT, DELIVER, PUSH, NESTED, DONE, FAIL
    } gemle_state_t;
    // Interruption types
    typedef enum logic [2:0] {
        EXT_INT = 3'h0, RSVD1 = 3'h1, NMI = 3'h2, HW_EXC = 3'h3,
        SW_INT = 3'h4, PRIV_SW_EXC = 3'h5, SW_EXC = 3'h6, OTHER = 3'h7
    } gemle_itype_t;
endpackage : gemle_pkg

// ---- hw/gemle_push_buf.sv ----
// Small memory holding the words pushed onto the guest stack
`timescale 1ns/1ns
`default_nettype none
module gemle_push_buf (
    input wire logic ref_clk,
    input wire logic writeEn,
    input wire logic [1:0] writeAddr,
    input wire logic [63:0] writeData,
    input wire logic [1:0] readAddr,
    output logic [63:0] readData
);
    logic [63:0] mem [0:3]; // Push words: flags, pointer, error code, spare
    // Write and registered read
    always_ff @(posedge ref_clk) begin
        if (writeEn) begin
            mem[writeAddr] <= writeData;
        end
        readData <= mem[readAddr];
    end
endmodule : gemle_push_buf
`default_nettype wire

// ---- hw/gemle_rec_check.sv ----
// Combinational-to-registered check of one register load record
`timescale 1ns/1ns
`default_nettype none
`include "gemle_map.svh"
module gemle_rec_check (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic checkStrobe,
    input wire logic [127:0] record,
    input wire logic entryInMgmtMode,
    input wire logic idxMgmtOnly,
    input wire logic idxForbidden,
    input wire logic writeWouldFault,
    output logic recordFail
);
    ////////////////////////////////////////////////////////////////////////
    logic next_recordFail; // Next failure verdict
    logic [31:0] idx; // Register index of the record
    always_comb begin
        idx = record[31:0];
        next_recordFail = recordFail;
        if (checkStrobe) begin
            next_recordFail = (idx == `GEMLE_IDX_FS_BASE) || (idx == `GEMLE_IDX_GS_BASE)
                || (idx[31:8] == `GEMLE_IDX_CTRL_HI)
                || (idxMgmtOnly && !entryInMgmtMode) || idxForbidden
                || (record[63:32] != 32'h0000_0000)
                || writeWouldFault;
        end
    end
    // Register the verdict
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            recordFail <= 1'b0;
        end else begin
            recordFail <= next_recordFail;
        end
    end
endmodule : gemle_rec_check
`default_nettype wire

// ---- testbench/gemle_entry_assertions.sv ----
// Port-level checks for the guest entry block
`timescale 1ns/1ns
`default_nettype none
module gemle_entry_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic entryStart,
    input wire logic [31:0] loadCount,
    input wire logic [31:0] intrInfo,
    input wire logic [63:0] guestIp,
    input wire logic virtNmiCtl,
    input wire logic watchCancel,
    input wire logic msrWrite,
    input wire logic [31:0] msrIdx,
    input wire logic [63:0] msrData,
    input wire logic entryFail,
    input wire logic entryDone,
    input wire logic deliverVec,
    input wire logic [7:0] deliverVector,
    input wire logic guestExit,
    input wire logic [63:0] exitSavedIp,
    input wire logic vnmiBlock,
    input wire logic debugRegWrite
);
    logic busy, next_busy; // Entry in flight
    logic [31:0] wrCnt, next_wrCnt; // Register writes in this entry
    // Track the entry window and count its writes
    always_comb begin
        next_busy = busy;
        next_wrCnt = msrWrite ? wrCnt + 32'h0000_0001 : wrCnt;
        if (entryStart && !busy) begin
            next_busy = 1'b1;
            next_wrCnt = 32'h0000_0000;
        end else if (entryDone || entryFail) begin
            next_busy = 1'b0;
        end
    end
    // Register the tracking state
    always_ff @(posedge ref_clk) begin
        busy <= rst ? 1'b0 : next_busy;
        wrCnt <= rst ? 32'h0000_0000 : next_wrCnt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Quiet span after a failed entry
    sequence s_quiet;
        (!deliverVec && !entryDone) [*4];
    endsequence
    a_watch_cancel: assert property (entryStart && !busy |=> watchCancel)
        else $error("watch not cancelled");
    a_bad_index: assert property (msrWrite |-> msrIdx != 32'hC000_0100 &&
        msrIdx != 32'hC000_0101 && msrIdx[31:8] != 24'h00_0008) else $error("refused index written");
    a_lma_kept: assert property (msrWrite && msrIdx == 32'hC000_0080 |-> !msrData[10])
        else $error("long mode flag written");
    a_fail_ends: assert property (entryFail |=> s_quiet)
        else $error("activity after failed entry");
    a_inject_last: assert property (deliverVec |-> wrCnt == loadCount)
        else $error("delivery before all records");
    a_vector_used: assert property (deliverVec |-> deliverVector == intrInfo[7:0])
        else $error("wrong vector delivered");
    a_exit_ip: assert property (guestExit |-> exitSavedIp == guestIp)
        else $error("saved pointer adjusted");
    a_debug_quiet: assert property (!debugRegWrite)
        else $error("debug register written");
    a_vnmi_held: assert property (entryDone && intrInfo[31] && intrInfo[10:8] == 3'h2 &&
        virtNmiCtl |-> vnmiBlock) else $error("virtual nmi blocking lost");
endmodule : gemle_entry_assertions
bind gemle_entry gemle_entry_assertions chk_u (.*);
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the guest entry block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    // Design inputs
    logic ref_clk = 1'b0, rst = 1'b1, entryStart = 1'b0, entryInMgmtMode = 1'b0, recValid = 1'b0;
    logic idxMgmtOnly = 1'b0, idxForbidden = 1'b0, writeWouldFault = 1'b0, v86Mode = 1'b0;
    logic v86Ext = 1'b0, redirBit = 1'b0, deliveryFault = 1'b0, virtNmiCtl = 1'b1;
    logic [31:0] loadCount = '0, intrInfo = '0, entryErrCode = '0, entryInstrLen = '0, excBitmap = '0;
    logic [127:0] recData = '0;
    logic [63:0] guestFlags = '0, guestIp = '0;
    logic [1:0] descPriv = 2'h3, curPriv = 2'h0;
    logic [7:0] nestVector = 8'h0D;
    // Design outputs
    logic watchCancel, recRead, msrWrite, entryFail, entryDone, deliverVec, useVecTable;
    logic mtfPending, guestExit, pushValid, vnmiBlock, debugRegWrite;
    logic [31:0] recIndex, msrIdx;
    logic [63:0] msrData, exitSavedIp, pushWord;
    logic [7:0] deliverVector, lastVec;
    // Model queues and counters
    logic [127:0] recQ[$];
    logic [2:0] attrQ[$];
    logic [63:0] idxQ[$], wrQ[$], pushQ[$], eIdx[$], eWr[$], ePush[$], ip, er;
    logic [15:0] seed = 16'h004E, r;
    logic [2:0] tys [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    int badCount = 0, checksDone = 0, dones, fails, dlv, exits, pend = 0;

    gemle_entry dut_u (.*);

    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // One record per request; data scrambled while not valid
    always @(posedge ref_clk) begin
        recValid <= !recRead && pend == 1 && recQ.size() > 0;
        if (recRead) begin
            recData <= ~recData;
            pend <= 1;
        end else if (pend == 1 && recQ.size() > 0) begin
            recData <= recQ.pop_front();
            {idxMgmtOnly, idxForbidden, writeWouldFault} <= attrQ.pop_front();
            pend <= 0;
        end
    end
    // Collect what the design reports
    always @(posedge ref_clk) begin
        if (msrWrite) begin
            idxQ.push_back({32'h0, msrIdx});
            wrQ.push_back(msrData);
        end
        if (pushValid) pushQ.push_back(pushWord);
        if (deliverVec) lastVec = deliverVector;
        if (deliverVec) dlv++;
        if (entryDone) dones++;
        if (entryFail) fails++;
        if (guestExit) exits++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Shift register random source
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    // Compare one value
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Compare a captured queue with its expectation
    task automatic cmpq(ref logic [63:0] g[$], ref logic [63:0] e[$], input string m);
        chk(g.size(), e.size(), m);
        foreach (e[i]) chk(g[i], e[i], m);
    endtask : cmpq
    // Forget the previous entry
    task automatic clr();
        recQ.delete();
        attrQ.delete();
        eIdx.delete();
        eWr.delete();
        ePush.delete();
    endtask : clr
    // Queue a record; ok says whether it should be written
    task automatic add_rec(input logic [31:0] idx, input logic [31:0] res, input logic [63:0] d,
                           input logic [2:0] attr, input logic ok);
        recQ.push_back({d, res, idx});
        attrQ.push_back(attr);
        if (ok) eIdx.push_back({32'h0, idx});
        if (ok) eWr.push_back(idx == 32'hC000_0080 ? d & ~64'h0400 : d);
    endtask : add_rec
    // Set the event and the words it should push
    task automatic set_ev(input logic [2:0] t, input logic [7:0] v, input logic e,
                          input logic [63:0] fi, input logic [63:0] fe);
        logic [31:0] ln;
        ln = 32'h0000_0003 + {29'h0, t};
        ip = {rnd(), rnd(), rnd(), rnd()};
        er = {48'h0, rnd()};
        intrInfo <= {1'b1, 19'h0, e, t, v};
        guestFlags <= fi;
        guestIp <= ip;
        entryInstrLen <= ln;
        entryErrCode <= er[31:0];
        ePush.push_back(fe);
        ePush.push_back(t >= 3'h4 ? ip + {32'h0, ln} : ip);
        if (e) ePush.push_back(er);
    endtask : set_ev
    // Start one entry and wait for its end
    task automatic run_entry(input int n);
        int k;
        {dones, fails, dlv, exits} = '0;
        idxQ.delete();
        wrQ.delete();
        pushQ.delete();
        entryStart <= 1'b1;
        @(posedge ref_clk);
        entryStart <= 1'b0;
        for (k = 0; k < 500 && dones + fails == 0; k++) @(posedge ref_clk);
        chk(dones + fails, 1, "no end");
        repeat (6) @(posedge ref_clk);
        $display("test %0d done", n);
    endtask : run_entry
    // Print the counts and the verdict, then stop
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        // Every vectored type with every bitmap bit set
        excBitmap <= 32'hFFFF_FFFF;
        loadCount <= 32'h0000_0003;
        foreach (tys[j]) begin
            clr();
            r = rnd();
            add_rec({20'h0_0001, r[11:0]}, '0, {rnd(), rnd(), rnd(), rnd()}, 3'h0, 1'b1);
            add_rec({20'h0_0002, r[11:0]}, '0, {rnd(), rnd(), rnd(), rnd()}, 3'h0, 1'b1);
            add_rec(32'hC000_0080, '0, {rnd(), rnd(), rnd(), rnd()} | 64'h0400, 3'h0, 1'b1);
            set_ev(tys[j], r[15:8], tys[j][0], {47'h0, 1'b1, r}, {47'h0, 1'b1, r});
            run_entry(1);
            cmpq(idxQ, eIdx, "write index");
            cmpq(wrQ, eWr, "write data");
            cmpq(pushQ, ePush, "stack words");
            chk(dlv, 1, "delivery count");
            chk(lastVec, r[15:8], "delivered vector");
            if (tys[j] == 3'h2) chk(vnmiBlock, 1, "nmi blocking");
        end
        // Each kind of bad record; the last kind passes in management mode
        excBitmap <= '0;
        for (int k = 0; k < 8; k++) begin
            clr();
            entryInMgmtMode <= (k == 7);
            add_rec(32'h0000_1000, '0, 64'h1, 3'h0, 1'b1);
            add_rec(k == 0 ? 32'hC000_0100 : k == 1 ? 32'hC000_0101 : k == 2 ? 32'h0000_0830 :
                    32'h0000_1001, k == 5 ? 32'h0000_0100 : '0, 64'h2,
                    (k == 3 || k == 7) ? 3'h4 : k == 4 ? 3'h2 : k == 6 ? 3'h1 : 3'h0, k == 7);
            add_rec(32'h0000_1002, '0, 64'h3, 3'h0, k == 7);
            set_ev(3'h0, 8'h20, 1'b0, 64'h2, 64'h2);
            run_entry(2);
            chk(fails, k != 7, "entry failure");
            chk(dones, k == 7, "entry done");
            cmpq(idxQ, eIdx, "records written");
            chk(dlv, k == 7, "delivery after failure");
        end
        // Other-event type with vector zero
        clr();
        loadCount <= 32'h0000_0001;
        add_rec(32'h0000_1000, '0, 64'h5, 3'h0, 1'b1);
        set_ev(3'h7, 8'h00, 1'b0, 64'h2, 64'h2);
        run_entry(3);
        chk(mtfPending, 1, "monitor trap pending");
        chk(dlv + pushQ.size(), 0, "event delivered");
        // Software interrupt into 8086 mode, redirected through the vector table
        clr();
        v86Mode <= 1'b1;
        v86Ext <= 1'b1;
        add_rec(32'h0000_1000, '0, 64'h5, 3'h0, 1'b1);
        set_ev(3'h4, 8'h21, 1'b0, 64'h0008_0000, 64'h0008_3200);
        run_entry(4);
        chk(useVecTable, 1, "vector table");
        cmpq(pushQ, ePush, "8086 stack words");
        v86Mode <= 1'b0;
        // Nested exception: exiting, then hardware and software types
        deliveryFault <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            clr();
            add_rec(32'h0000_1000, '0, 64'h5, 3'h0, 1'b1);
            excBitmap <= m == 0 ? 32'h0000_2000 : '0;
            set_ev(m == 1 ? 3'h3 : 3'h4, 8'h40, 1'b0, 64'h2, 64'h2);
            run_entry(5);
            chk(exits, m == 0, "nested exit");
            if (m == 0) chk(exitSavedIp, ip, "saved pointer");
            if (m != 0) chk(pushQ[1], ip, "pushed pointer");
            if (m != 0) chk(pushQ[2][0], m == 1, "external flag");
        end
        conclude();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        badCount++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
